// >>> design/tcucs_pkg.sv
// package: register map, field positions and reset values of the timer control block
`default_nettype none
package tcucs_pkg;
  localparam int ADDR_W = 12;
  // printed offsets are register indices; byte address is index times four
  localparam logic [7:0] IDX_SERIAL_BUFFER = 8'h99;
  localparam logic [7:0] IDX_BAUD_RELOAD = 8'h9A;
  localparam logic [7:0] IDX_SLAVE_ADDRESS = 8'hA9;
  localparam logic [7:0] IDX_SLAVE_ADDRESS_MASK = 8'hB9;
  localparam logic [7:0] IDX_SECOND_TIMER_CONTROL = 8'hC8;
  localparam logic [ADDR_W-1:0] ADR_SERIAL_BUFFER = {2'h0, IDX_SERIAL_BUFFER, 2'h0};
  localparam logic [ADDR_W-1:0] ADR_BAUD_RELOAD = {2'h0, IDX_BAUD_RELOAD, 2'h0};
  localparam logic [ADDR_W-1:0] ADR_SLAVE_ADDRESS = {2'h0, IDX_SLAVE_ADDRESS, 2'h0};
  localparam logic [ADDR_W-1:0] ADR_SLAVE_ADDRESS_MASK = {2'h0, IDX_SLAVE_ADDRESS_MASK, 2'h0};
  localparam logic [ADDR_W-1:0] ADR_SECOND_TIMER_CONTROL =
    {2'h0, IDX_SECOND_TIMER_CONTROL, 2'h0};
  // block-local registers
  localparam logic [ADDR_W-1:0] ADR_COUNT = 12'h000;
  localparam logic [ADDR_W-1:0] ADR_RELOAD_CAPTURE = 12'h004;
  localparam logic [ADDR_W-1:0] ADR_CONFIG = 12'h008;
  localparam logic [ADDR_W-1:0] ADR_IRQ_STATUS = 12'h00C;
  localparam logic [ADDR_W-1:0] ADR_IRQ_MASK = 12'h010;
  // control register fields
  localparam int CTL_OVERFLOW_FLAG = 7;
  localparam int CTL_EXTERNAL_EVENT_FLAG = 6;
  localparam int CTL_RX_CLOCK_SELECT = 5;
  localparam int CTL_TX_CLOCK_SELECT = 4;
  localparam int CTL_EXTERNAL_TRIGGER_ENABLE = 3;
  localparam int CTL_RUN_CONTROL = 2;
  localparam int CTL_COUNT_SOURCE_SELECT = 1;
  localparam int CTL_CAPTURE_RELOAD_SELECT = 0;
  // config register fields
  localparam int CFG_UP_DOWN_ENABLE = 0;
  localparam int CFG_SERIAL_MODE_LSB = 1;
  localparam int CFG_SERIAL_MODE_W = 2;
  // status and mask fields
  localparam int IRQ_W = 2;
  localparam int IRQ_OVERFLOW = 0;
  localparam int IRQ_EXTERNAL = 1;
  // reset values
  localparam logic [7:0] RST_SECOND_TIMER_CONTROL = 8'h00;
  localparam logic [7:0] RST_SERIAL_BUFFER = 8'h00;
  localparam logic [7:0] RST_BAUD_RELOAD = 8'h00;
  localparam logic [7:0] RST_SLAVE_ADDRESS = 8'h00;
  localparam logic [7:0] RST_SLAVE_ADDRESS_MASK = 8'h00;
  // serial port modes
  typedef enum logic [1:0] {
    SMODE_SHIFT = 2'h0,
    SMODE_UART8_VAR = 2'h1,
    SMODE_UART9_FIX = 2'h2,
    SMODE_UART9_VAR = 2'h3
  } tcucs_smode_t;
endpackage
`default_nettype wire

// >>> design/tcucs_clk_if.sv
// interface: overflow sources and serial clock picks between control and mux
`default_nettype none
interface tcucs_clk_if;
  logic other_ovf;
  logic this_ovf;
  logic rx_sel;
  logic tx_sel;
  logic [1:0] smode;
  logic rx_tick;
  logic tx_tick;
  modport ctrl (output other_ovf, output this_ovf, output rx_sel, output tx_sel,
    output smode, input rx_tick, input tx_tick);
  modport mux (input other_ovf, input this_ovf, input rx_sel, input tx_sel,
    input smode, output rx_tick, output tx_tick);
endinterface
`default_nettype wire

// >>> design/tcucs_fall_sync.sv
// module: two-stage pin synchroniser with falling edge pulse
`default_nettype none
module tcucs_fall_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // pin and edge
  input wire logic pin_in,
  output logic fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
  } tcucs_sync_t;
  tcucs_sync_t r;
  tcucs_sync_t n;

  always_comb begin
    n = r;
    n.s1 = pin_in;
    n.s2 = r.s1;
    n.prev = r.s2;
    fall = r.prev & ~r.s2;
  end

  // pin idles high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '1;
    end else if (ce) begin
      r <= n;
    end
  end
endmodule
`default_nettype wire

// >>> design/tcucs_uart_clk_mux.sv
// module: picks the overflow that clocks serial receive and transmit
`default_nettype none
module tcucs_uart_clk_mux (
  // selection link
  tcucs_clk_if.mux cif
);
  logic var_mode;

  always_comb begin
    var_mode = (cif.smode == tcucs_pkg::SMODE_UART8_VAR) ||
      (cif.smode == tcucs_pkg::SMODE_UART9_VAR);
    // only modes 1 and 3 take a timer clock
    cif.rx_tick = var_mode & (cif.rx_sel ? cif.this_ovf : cif.other_ovf); // RULE6
    cif.tx_tick = var_mode & (cif.tx_sel ? cif.this_ovf : cif.other_ovf); // RULE10
  end
endmodule
`default_nettype wire

// >>> design/tcucs_timer2_ctrl.sv
// module: second timer control, capture/reload and serial clock select, AHB-Lite slave
// Function
// RULE1: control bits ordered overflow down to capture/reload
// RULE2: overflow sets only without serial clocks; software clears
// RULE3: enabled trigger falling edge captures/reloads, sets flag
// RULE4: external flag requests timer interrupt
// RULE5: up/down enable blocks external flag interrupt
// RULE6: receive clock select picks this/other overflow
// RULE7: source select zero counts peripheral clock
// RULE8: source select one counts count-pin falls
// RULE9: software keeps source zero in clock-out mode
// RULE10: transmit clock select picks this/other overflow
// RULE11: capture/reload select ignored while serial clocking
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`default_nettype none
module tcucs_timer2_ctrl #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // pins
  input wire logic external_trigger_pin,
  input wire logic external_count_input,
  // other timer
  input wire logic other_timer_overflow,
  // serial port clocks
  output logic rx_clock_tick,
  output logic tx_clock_tick,
  // timer events and interrupts
  output logic timer_overflow,
  output logic timer_irq_req,
  output logic irq
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] serial_buffer;
    logic [7:0] baud_reload;
    logic [7:0] slave_address;
    logic [7:0] slave_address_mask;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] rcap;
    logic up_down_enable;
    logic [1:0] smode;
    logic [tcucs_pkg::IRQ_W-1:0] ists;
    logic [tcucs_pkg::IRQ_W-1:0] imask;
    logic wr_pend;
    logic [tcucs_pkg::ADDR_W-1:0] wr_addr;
    logic [31:0] rdata;
    logic ready;
    logic resp;
    logic irq;
    logic tirq;
    logic rxt;
    logic txt;
    logic tovf;
  } tcucs_state_t;

  tcucs_state_t r;
  tcucs_state_t n;
  logic trig_fall;
  logic cnt_fall;
  logic tick;
  logic ovf;
  logic baud;
  logic trig;
  logic ovf_set;
  logic ap;
  logic hit;
  logic [31:0] rd_mux;

  if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
    $error("CNT_W must lie between 2 and 16");
  end

  tcucs_clk_if cif ();

  tcucs_fall_sync u_trig_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .ce(ce),
    .pin_in(external_trigger_pin),
    .fall(trig_fall)
  );

  tcucs_fall_sync u_count_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .ce(ce),
    .pin_in(external_count_input),
    .fall(cnt_fall)
  );

  tcucs_uart_clk_mux u_clk_mux (
    .cif(cif.mux)
  );

  assign cif.other_ovf = other_timer_overflow;
  assign cif.this_ovf = ovf;
  assign cif.rx_sel = r.ctrl[tcucs_pkg::CTL_RX_CLOCK_SELECT];
  assign cif.tx_sel = r.ctrl[tcucs_pkg::CTL_TX_CLOCK_SELECT];
  assign cif.smode = r.smode;

  // read mux in address phase
  always_comb begin
    rd_mux = 32'h00000000;
    case (haddr[tcucs_pkg::ADDR_W-1:0])
      tcucs_pkg::ADR_SECOND_TIMER_CONTROL: rd_mux[7:0] = r.ctrl; // RULE1
      tcucs_pkg::ADR_SERIAL_BUFFER: rd_mux[7:0] = r.serial_buffer;
      tcucs_pkg::ADR_BAUD_RELOAD: rd_mux[7:0] = r.baud_reload;
      tcucs_pkg::ADR_SLAVE_ADDRESS: rd_mux[7:0] = r.slave_address;
      tcucs_pkg::ADR_SLAVE_ADDRESS_MASK: rd_mux[7:0] = r.slave_address_mask;
      tcucs_pkg::ADR_COUNT: rd_mux[CNT_W-1:0] = r.count;
      tcucs_pkg::ADR_RELOAD_CAPTURE: rd_mux[CNT_W-1:0] = r.rcap;
      tcucs_pkg::ADR_CONFIG: rd_mux[2:0] = {r.smode, r.up_down_enable};
      tcucs_pkg::ADR_IRQ_STATUS: rd_mux[tcucs_pkg::IRQ_W-1:0] = r.ists;
      tcucs_pkg::ADR_IRQ_MASK: rd_mux[tcucs_pkg::IRQ_W-1:0] = r.imask;
      default: rd_mux = 32'h00000000;
    endcase
    if (!hit) begin
      rd_mux = 32'h00000000;
    end
  end

  always_comb begin
    n = r;
    hit = haddr[31:tcucs_pkg::ADDR_W] == '0;
    ap = hsel & htrans[1] & hready;
    baud = r.ctrl[tcucs_pkg::CTL_RX_CLOCK_SELECT] | r.ctrl[tcucs_pkg::CTL_TX_CLOCK_SELECT];
    // internal clock or synchronised pin falls
    tick = r.ctrl[tcucs_pkg::CTL_RUN_CONTROL] &
      (r.ctrl[tcucs_pkg::CTL_COUNT_SOURCE_SELECT] ? cnt_fall : 1'b1); // RULE7 RULE8
    ovf = tick && (r.count == '1);
    ovf_set = ovf & ~baud; // RULE2
    trig = r.ctrl[tcucs_pkg::CTL_EXTERNAL_TRIGGER_ENABLE] & trig_fall;
    // counting datapath
    if (tick) begin
      n.count = r.count + 1'b1; // RULE7 RULE8
    end
    if (ovf && (baud || !r.ctrl[tcucs_pkg::CTL_CAPTURE_RELOAD_SELECT])) begin
      n.count = r.rcap; // RULE11
    end
    if (trig) begin
      if (r.ctrl[tcucs_pkg::CTL_CAPTURE_RELOAD_SELECT] && !baud) begin
        n.rcap = r.count; // RULE3 RULE11
      end else begin
        n.count = r.rcap; // RULE3 RULE11
      end
    end
    // write data phase
    if (r.wr_pend) begin
      case (r.wr_addr)
        tcucs_pkg::ADR_SECOND_TIMER_CONTROL: n.ctrl = hwdata[7:0]; // RULE1
        tcucs_pkg::ADR_SERIAL_BUFFER: n.serial_buffer = hwdata[7:0];
        tcucs_pkg::ADR_BAUD_RELOAD: n.baud_reload = hwdata[7:0];
        tcucs_pkg::ADR_SLAVE_ADDRESS: n.slave_address = hwdata[7:0];
        tcucs_pkg::ADR_SLAVE_ADDRESS_MASK: n.slave_address_mask = hwdata[7:0];
        tcucs_pkg::ADR_COUNT: n.count = hwdata[CNT_W-1:0];
        tcucs_pkg::ADR_RELOAD_CAPTURE: n.rcap = hwdata[CNT_W-1:0];
        tcucs_pkg::ADR_CONFIG: begin
          n.up_down_enable = hwdata[tcucs_pkg::CFG_UP_DOWN_ENABLE];
          n.smode = hwdata[tcucs_pkg::CFG_SERIAL_MODE_LSB +: tcucs_pkg::CFG_SERIAL_MODE_W];
        end
        tcucs_pkg::ADR_IRQ_MASK: n.imask = hwdata[tcucs_pkg::IRQ_W-1:0];
        default: n.wr_addr = r.wr_addr;
      endcase
    end
    // hardware sets win over a software write in the same cycle
    if (ovf_set) begin
      n.ctrl[tcucs_pkg::CTL_OVERFLOW_FLAG] = 1'b1; // RULE2
    end
    if (trig) begin
      n.ctrl[tcucs_pkg::CTL_EXTERNAL_EVENT_FLAG] = 1'b1; // RULE3
    end
    // address phase
    n.wr_pend = ap & hwrite & hit;
    n.wr_addr = haddr[tcucs_pkg::ADDR_W-1:0];
    if (ap && !hwrite) begin
      n.rdata = rd_mux;
    end
    if (ap && !hwrite && hit && haddr[tcucs_pkg::ADDR_W-1:0] == tcucs_pkg::ADR_IRQ_STATUS) begin
      n.ists = '0;
    end
    n.ists[tcucs_pkg::IRQ_OVERFLOW] = n.ists[tcucs_pkg::IRQ_OVERFLOW] | ovf_set;
    n.ists[tcucs_pkg::IRQ_EXTERNAL] = n.ists[tcucs_pkg::IRQ_EXTERNAL] | trig;
    n.ready = 1'b1;
    n.resp = 1'b0;
    n.irq = |(n.ists & n.imask);
    n.tirq = n.ctrl[tcucs_pkg::CTL_OVERFLOW_FLAG] |
      (n.ctrl[tcucs_pkg::CTL_EXTERNAL_EVENT_FLAG] & ~n.up_down_enable); // RULE4 RULE5
    n.rxt = cif.rx_tick; // RULE6
    n.txt = cif.tx_tick; // RULE10
    n.tovf = ovf;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.ctrl <= tcucs_pkg::RST_SECOND_TIMER_CONTROL;
      r.serial_buffer <= tcucs_pkg::RST_SERIAL_BUFFER;
      r.baud_reload <= tcucs_pkg::RST_BAUD_RELOAD;
      r.slave_address <= tcucs_pkg::RST_SLAVE_ADDRESS;
      r.slave_address_mask <= tcucs_pkg::RST_SLAVE_ADDRESS_MASK;
      r.ready <= 1'b1;
    end else if (ce) begin
      r <= n;
    end
  end

  assign hreadyout = r.ready;
  assign hresp = r.resp;
  assign hrdata = r.rdata;
  assign rx_clock_tick = r.rxt;
  assign tx_clock_tick = r.txt;
  assign timer_overflow = r.tovf;
  assign timer_irq_req = r.tirq;
  assign irq = r.irq;

  // checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic ctl_wr;
  assign ctl_wr = r.wr_pend && (r.wr_addr == tcucs_pkg::ADR_SECOND_TIMER_CONTROL);

  sequence seq_baud_ovf;
    ce && ovf && baud;
  endsequence

  sequence seq_clean_ovf;
    ce && ovf && !baud;
  endsequence

  sequence seq_var_mode;
    r.smode == tcucs_pkg::SMODE_UART8_VAR || r.smode == tcucs_pkg::SMODE_UART9_VAR;
  endsequence

  sequence seq_trig_capture;
    ce && trig && r.ctrl[tcucs_pkg::CTL_CAPTURE_RELOAD_SELECT] && !baud;
  endsequence

  sequence seq_trig_reload;
    ce && trig && !(r.ctrl[tcucs_pkg::CTL_CAPTURE_RELOAD_SELECT] && !baud);
  endsequence

  AST_CTRL_WRITE: assert property ( // RULE1
    (ce && ctl_wr && !ovf_set && !trig) |=> (r.ctrl == $past(hwdata[7:0])))
    else $error("control write did not land in bit order");

  AST_OVF_SET: assert property ( // RULE2
    seq_clean_ovf |=> r.ctrl[tcucs_pkg::CTL_OVERFLOW_FLAG] ##0 r.ists[tcucs_pkg::IRQ_OVERFLOW])
    else $error("overflow flag not set on overflow");

  AST_OVF_BAUD_QUIET: assert property ( // RULE2
    (seq_baud_ovf ##0 !ctl_wr) |=> $stable(r.ctrl[tcucs_pkg::CTL_OVERFLOW_FLAG]))
    else $error("overflow flag moved while serial clocking");

  AST_OVF_STICKY: assert property ( // RULE2
    (ce && r.ctrl[tcucs_pkg::CTL_OVERFLOW_FLAG] && !ctl_wr)
      |=> r.ctrl[tcucs_pkg::CTL_OVERFLOW_FLAG])
    else $error("overflow flag cleared by hardware");

  AST_EXT_SET: assert property ( // RULE3
    (ce && trig) |=> r.ctrl[tcucs_pkg::CTL_EXTERNAL_EVENT_FLAG] ##1 !ce || timer_irq_req || r.up_down_enable)
    else $error("external flag or its request missing after trigger");

  AST_EXT_REQ: assert property ( // RULE4
    (r.ctrl[tcucs_pkg::CTL_EXTERNAL_EVENT_FLAG] && !r.up_down_enable) |-> timer_irq_req)
    else $error("external flag without timer request");

  AST_UP_DOWN_ENABLE_BLOCK: assert property ( // RULE5
    (!r.ctrl[tcucs_pkg::CTL_OVERFLOW_FLAG] && r.up_down_enable) |-> !timer_irq_req)
    else $error("external flag requested interrupt in up/down mode");

  AST_RX_THIS: assert property ( // RULE6
    (seq_var_mode ##0 (ce && r.ctrl[tcucs_pkg::CTL_RX_CLOCK_SELECT] && ovf))
      |=> rx_clock_tick)
    else $error("receive clock missed this timer overflow");

  AST_TX_OTHER: assert property ( // RULE10
    (seq_var_mode ##0 (ce && !r.ctrl[tcucs_pkg::CTL_TX_CLOCK_SELECT]))
      |=> (tx_clock_tick == $past(other_timer_overflow)))
    else $error("transmit clock did not follow other timer");

  AST_COUNT_INT: assert property ( // RULE7
    (ce && tick && !r.ctrl[tcucs_pkg::CTL_COUNT_SOURCE_SELECT] && !ovf && !trig && !r.wr_pend)
      |=> (r.count == $past(r.count) + 1'b1))
    else $error("timer did not step on the peripheral clock");

  AST_COUNT_PIN_IDLE: assert property ( // RULE8
    (ce && r.ctrl[tcucs_pkg::CTL_COUNT_SOURCE_SELECT] && !cnt_fall && !trig && !r.wr_pend)
      |=> $stable(r.count))
    else $error("counter moved without a pin fall");

  AST_BAUD_RELOAD: assert property ( // RULE11
    (seq_baud_ovf ##0 !trig && !r.wr_pend) |=> (r.count == $past(r.rcap)))
    else $error("no forced reload while serial clocking");

  AST_TRIG_CAPTURE: assert property ( // RULE3
    (seq_trig_capture ##0 !r.wr_pend) |=> (r.rcap == $past(r.count)))
    else $error("trigger did not capture the count");

  AST_TRIG_RELOAD: assert property ( // RULE3
    (seq_trig_reload ##0 !r.wr_pend) |=> (r.count == $past(r.rcap)))
    else $error("trigger did not reload the count");

  AST_TRIG_OFF: assert property ( // RULE3
    (ce && !r.ctrl[tcucs_pkg::CTL_EXTERNAL_TRIGGER_ENABLE] &&
      !r.ctrl[tcucs_pkg::CTL_EXTERNAL_EVENT_FLAG] && !ctl_wr)
      |=> !r.ctrl[tcucs_pkg::CTL_EXTERNAL_EVENT_FLAG])
    else $error("external flag set with trigger disabled");

  AST_CAP_WRAP: assert property ( // RULE11
    (seq_clean_ovf ##0 (r.ctrl[tcucs_pkg::CTL_CAPTURE_RELOAD_SELECT] && !trig && !r.wr_pend))
      |=> (r.count == '0))
    else $error("capture mode did not wrap on overflow");

  AST_RX_OTHER: assert property ( // RULE6
    (seq_var_mode ##0 (ce && !r.ctrl[tcucs_pkg::CTL_RX_CLOCK_SELECT]))
      |=> (rx_clock_tick == $past(other_timer_overflow)))
    else $error("receive clock did not follow other timer");

  AST_TX_THIS: assert property ( // RULE10
    (seq_var_mode ##0 (ce && r.ctrl[tcucs_pkg::CTL_TX_CLOCK_SELECT] && ovf))
      |=> tx_clock_tick)
    else $error("transmit clock missed this timer overflow");

  AST_FIXED_MODE_QUIET: assert property ( // RULE6 RULE10
    (ce && (r.smode == tcucs_pkg::SMODE_SHIFT || r.smode == tcucs_pkg::SMODE_UART9_FIX))
      |=> (!rx_clock_tick && !tx_clock_tick))
    else $error("serial clock tick outside the timer clocked modes");

  AST_OVF_PULSE: assert property ( // RULE2
    (ce && ovf) |=> timer_overflow)
    else $error("overflow pulse missing");

  AST_BUS_OKAY: assert property (
    hreadyout && !hresp)
    else $error("bus answer not ready and okay");

  AST_IRQ_LEVEL: assert property (
    irq == |(r.ists & r.imask))
    else $error("interrupt output disagrees with status and mask");
endmodule
`default_nettype wire

// >>> verif/tcucs_far_model.sv
// far side model: trigger pin, count pin and other timer overflow
`default_nettype none
module tcucs_far_model (
  // clock
  input wire logic hclk,
  // far side signals
  output logic external_trigger_pin,
  output logic external_count_input,
  output logic other_timer_overflow
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins idle high, falls are held long enough for the synchroniser
  initial begin
    external_trigger_pin = 1'b1;
    external_count_input = 1'b1;
    other_timer_overflow = 1'b0;
  end
  task automatic trig_fall();
    @(posedge hclk);
    external_trigger_pin <= 1'b0;
    repeat (4) @(posedge hclk);
    external_trigger_pin <= 1'b1;
    repeat (4) @(posedge hclk);
  endtask
  task automatic count_fall();
    @(posedge hclk);
    external_count_input <= 1'b0;
    repeat (4) @(posedge hclk);
    external_count_input <= 1'b1;
    repeat (4) @(posedge hclk);
  endtask
  task automatic other_pulse();
    @(posedge hclk);
    other_timer_overflow <= 1'b1;
    @(posedge hclk);
    other_timer_overflow <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask
endmodule
`default_nettype wire

// >>> verif/test_timer2_control_uart_clock_select.sv
// testbench: register access, timer events and serial clock selection
`default_nettype none
module test_timer2_control_uart_clock_select;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_CTL = tcucs_pkg::ADR_SECOND_TIMER_CONTROL;
  localparam logic [11:0] A_CNT = tcucs_pkg::ADR_COUNT;
  localparam logic [11:0] A_RLD = tcucs_pkg::ADR_RELOAD_CAPTURE;
  localparam logic [11:0] A_CFG = tcucs_pkg::ADR_CONFIG;
  localparam logic [11:0] A_STS = tcucs_pkg::ADR_IRQ_STATUS;
  localparam logic [11:0] A_MSK = tcucs_pkg::ADR_IRQ_MASK;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic trig_pin, cnt_pin, other_ovf, rx_tick, tx_tick, ovf, irq_req, irq, ce_in;
  logic [11:0] uart_a [4];
  int mismatches, n_checks, n_rx, n_tx, n_ovf, b_rx, b_tx, b_ovf;

  tcucs_timer2_ctrl #(.CNT_W(16)) dut (.hclk(hclk), .hresetn(hresetn), .ce(ce_in),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .external_trigger_pin(trig_pin), .external_count_input(cnt_pin),
    .other_timer_overflow(other_ovf), .rx_clock_tick(rx_tick), .tx_clock_tick(tx_tick),
    .timer_overflow(ovf), .timer_irq_req(irq_req), .irq(irq));
  tcucs_far_model far (.hclk(hclk), .external_trigger_pin(trig_pin),
    .external_count_input(cnt_pin), .other_timer_overflow(other_ovf));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // event pulse counters
  always @(posedge hclk) begin
    if (rx_tick === 1'b1) n_rx++;
    if (tx_tick === 1'b1) n_tx++;
    if (ovf === 1'b1) n_ovf++;
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    // let the write land before anyone looks at outputs
    @(negedge hclk);
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  task automatic snap();
    b_rx = n_rx;
    b_tx = n_tx;
    b_ovf = n_ovf;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    print_verdict();
  end

  initial begin
    hresetn = 1'b0;
    ce_in = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    uart_a = '{tcucs_pkg::ADR_SERIAL_BUFFER, tcucs_pkg::ADR_BAUD_RELOAD,
      tcucs_pkg::ADR_SLAVE_ADDRESS, tcucs_pkg::ADR_SLAVE_ADDRESS_MASK};
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values, read/write, unmapped place
    rdc("control reset", A_CTL, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rdc("uart reg reset", uart_a[i], 32'h0);
      wr(uart_a[i], 32'hA5 + 32'(i));
      rdc("uart reg rw", uart_a[i], 32'hA5 + 32'(i));
    end
    wr(12'h0FC, 32'h5A);
    rdc("unmapped", 12'h0FC, 32'h0);
    chk("hresp", {31'h0, hresp}, 32'h0);
    // serial mode table against other timer overflow
    for (int m = 0; m < 4; m++) begin
      wr(A_CFG, 32'(m << 1));
      snap();
      far.other_pulse();
      chk("rx tick other", 32'(n_rx - b_rx), 32'(m % 2));
      chk("tx tick other", 32'(n_tx - b_tx), 32'(m % 2));
    end
    // overflow by count pin, auto-reload
    wr(A_MSK, 32'h3);
    wr(A_RLD, 32'h1234);
    wr(A_CNT, 32'hFFFF);
    wr(A_CTL, 32'h06);
    snap();
    far.count_fall();
    chk("overflow pulse", 32'(n_ovf - b_ovf), 32'h1);
    chk("no this rx", 32'(n_rx - b_rx), 32'h0);
    chk("irq req ovf", {31'h0, irq_req}, 32'h1);
    chk("irq ovf", {31'h0, irq}, 32'h1);
    rdc("reloaded", A_CNT, 32'h1234);
    repeat (20) @(posedge hclk);
    rdc("flag set stays", A_CTL, 32'h86);
    rdc("status ovf", A_STS, 32'h1);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    wr(A_CTL, 32'h06);
    rdc("flag sw clear", A_CTL, 32'h06);
    // capture mode wraps to zero
    wr(A_CNT, 32'hFFFF);
    wr(A_CTL, 32'h07);
    far.count_fall();
    rdc("wrap", A_CNT, 32'h0);
    rdc("flag cap", A_CTL, 32'h87);
    // this timer clocks serial port, forced reload, no flag
    wr(A_CTL, 32'h37);
    wr(A_CNT, 32'hFFFF);
    snap();
    far.count_fall();
    chk("rx tick this", 32'(n_rx - b_rx), 32'h1);
    chk("tx tick this", 32'(n_tx - b_tx), 32'h1);
    rdc("forced reload", A_CNT, 32'h1234);
    rdc("no flag serial", A_CTL, 32'h37);
    // trigger capture, masked then unmasked
    wr(A_MSK, 32'h0);
    xfer(1'b0, A_STS, 32'h0);
    wr(A_CTL, 32'h0B);
    wr(A_CNT, 32'h00AB);
    far.trig_fall();
    rdc("captured", A_RLD, 32'h00AB);
    rdc("ext flag", A_CTL, 32'h4B);
    chk("irq req ext", {31'h0, irq_req}, 32'h1);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(A_MSK, 32'h2);
    chk("irq unmasked", {31'h0, irq}, 32'h1);
    rdc("status ext", A_STS, 32'h2);
    wr(A_CFG, 32'h1);
    chk("updown blocks", {31'h0, irq_req}, 32'h0);
    wr(A_CFG, 32'h0);
    // trigger ignored while disabled
    wr(A_CTL, 32'h03);
    far.trig_fall();
    rdc("trig off", A_CTL, 32'h03);
    rdc("no capture", A_RLD, 32'h00AB);
    // trigger reload
    wr(A_RLD, 32'h0055);
    wr(A_CTL, 32'h0A);
    wr(A_CNT, 32'h0777);
    far.trig_fall();
    rdc("trig reload", A_CNT, 32'h0055);
    rdc("ext flag rl", A_CTL, 32'h4A);
    // clock enable low freezes synchroniser and counter
    wr(A_CTL, 32'h06);
    @(posedge hclk);
    ce_in <= 1'b0;
    far.count_fall();
    ce_in <= 1'b1;
    rdc("ce frozen", A_CNT, 32'h0055);
    far.count_fall();
    rdc("pin count", A_CNT, 32'h0056);
    // internal clock counting, source select held at zero
    wr(A_CNT, 32'h0);
    wr(A_CTL, 32'h04);
    wr(A_CTL, 32'h00);
    xfer(1'b0, A_CNT, 32'h0);
    chk("count runs", rd, 32'h3);
    print_verdict();
  end
endmodule
`default_nettype wire
